//--- include/compare_latch_consts.vh
`ifndef COMPARE_LATCH_CONSTS_VH
`define COMPARE_LATCH_CONSTS_VH
// Register byte addresses (32-bit aligned words, data in bits 7:0)
`define ADDR_CM_REGION 2'b00
`define ADDR_CAP_REGION 2'b11
`define ADDR_TIME_BASE_SEL 8'h80
`define ADDR_CH_ENABLE 8'h84
`define ADDR_RELOAD_LO 8'h88
`define ADDR_RELOAD_HI 8'h8c
`define ADDR_CAP_MODE 8'h90
`define ADDR_T2_CONTROL 8'h94
`define ADDR_EXT_FLAGS 8'h98
`define ADDR_CT_STATUS 8'h9c
// Field positions
`define EDGE_SEL_ZERO_BIT 0
`define EDGE_SEL_FOUR_BIT 1
`define CT_RUN_BIT 0
`define CT_OVF_BIT 1
// Reset values
`define RST_TIME_BASE_SEL 8'h00
`define RST_CH_ENABLE 8'h00
`define RST_CAP_MODE 5'h00
`define RST_T2_CONTROL 2'h0
`define RST_WORD16 16'h0000
// Counts
`define NUM_CM 8
`define NUM_CAP 5
`define TIMER_MAX 16'hffff
`endif

//--- hdl/capture_edge_detect.v
`timescale 1ns/1ps
// Samples capture pins once per cycle and flags a transition in the chosen direction
module capture_edge_detect #(
  parameter WIDTH = 5
) (
  input wire clk_sys, // System clock
  input wire sys_rst, // Async reset, active high
  input wire [WIDTH-1:0] pinIn, // Raw capture pins
  input wire [WIDTH-1:0] riseSel, // 1 = rising edge, 0 = falling edge
  output reg [WIDTH-1:0] edgeHit_r // One-cycle pulse per recognised edge
);

  reg [WIDTH-1:0] sync1_r;
  reg [WIDTH-1:0] sync2_r;
  reg [WIDTH-1:0] sync3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage sampler; stages two and three form consecutive samples
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // Start at the idle high pin level so release makes no false edge
      sync1_r <= {WIDTH{1'b1}};
      sync2_r <= {WIDTH{1'b1}};
      sync3_r <= {WIDTH{1'b1}};
      edgeHit_r <= {WIDTH{1'b0}};
    end
    else
    begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r; // [R13]
      // Two consecutive samples differing in the selected direction
      edgeHit_r <= (riseSel & sync2_r & ~sync3_r) | (~riseSel & ~sync2_r & sync3_r); // [R13]
    end
  end

endmodule // capture_edge_detect

//--- hdl/compare_latch_and_capture.v
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "compare_latch_consts.vh"
// Summary of operation
// [R1] Mode 1: low-byte write loads compare latch directly.
// [R2] Time base select bits reset to 0, giving compare mode 1.
// [R3] Mode 0: writes hit register latch; compare latch loads at timer overflow.
// [R4] Software preloads both latches via mode 1 then mode 0 sequence.
// [R5] Writing the reload register starts the compare timer.
// [R6] Channels on timer 2 always run in compare mode 1.
// [R7] Timer 2 channels transfer full 16 bits on low-byte write only.
// [R8] Software writes high byte first, then low byte.
// [R9] Four compare/capture and reload/capture registers latch timer 2 count.
// [R10] Capture mode 0: channels 1 to 3 capture on rising pin edge.
// [R11] Channels 0 and 4 capture falling, or rising when edge select set.
// [R12] Software sets port latch to one for capture input pins.
// [R13] Inputs sampled each cycle; two differing samples make a transition.
// [R14] Timer 2 count latched the cycle after transition detection.
// [R15] Mode 0 transition sets the channel's external request flag.
// [R16] Mode 1: low-byte write triggers capture in the following cycle.
// [R17] Software-triggered capture raises no request flag.
// [R18] Capture mode is selectable per capture register.
// [R19] Overflow transfer happens only if low byte written since last transfer.
// [R20] Compare result reaches output only while channel enable is set.
// [R21] Mode 1 high-byte write stores the byte, no capture.
module compare_latch_and_capture #(
  parameter NCM = `NUM_CM,
  parameter NCAP = `NUM_CAP
) (
  input wire clk_sys, // System clock, 50 MHz
  input wire sys_rst, // Async reset, active high
  input wire [7:0] address, // Avalon byte address
  input wire read, // Avalon read
  input wire write, // Avalon write
  input wire [31:0] writedata, // Avalon write data
  output reg [31:0] readdata, // Avalon read data
  output reg waitrequest, // Avalon wait
  input wire [15:0] timerTwoCount, // Timer 2 count, same clock
  input wire [NCAP-1:0] captureIn, // Capture pins, ch0..ch4
  output reg [NCM-1:0] compareOut, // Compare outputs
  output reg [NCAP-1:0] extRequestFlag // External request flags ch0..ch4
);

  // Replace one byte of a 16-bit word
  function [15:0] setByte;
    input [15:0] oldVal;
    input hiSel;
    input [7:0] b;
    begin
      setByte = hiSel ? {b, oldVal[7:0]} : {oldVal[15:8], b};
    end
  endfunction

  // Pick one byte of a 16-bit word, zero extended
  function [31:0] getByte;
    input [15:0] val;
    input hiSel;
    begin
      getByte = {24'h000000, hiSel ? val[15:8] : val[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  reg [15:0] cmReg [0:NCM-1]; // Register latches
  reg [15:0] cmLatch [0:NCM-1]; // Compare latches
  reg [NCM-1:0] cmLowWr_r; // Low byte written since last transfer
  reg [7:0] timeBaseSel_r; // 1 = compare timer (mode 0), 0 = timer 2 (mode 1)
  reg [7:0] chEnable_r;
  reg [15:0] reload_r;
  reg [15:0] ctCount_r;
  reg ctRun_r;
  reg ctOvfFlag_r;
  reg [15:0] capReg [0:NCAP-1];
  reg [NCAP-1:0] capMode_r; // 1 = software-triggered capture
  reg [1:0] t2Control_r;
  reg [NCAP-1:0] swCap_r; // Pending software capture
  wire [NCAP-1:0] edgeHit;
  wire [NCAP-1:0] riseSel;
  integer i; // Loop index, compare registers
  integer j; // Loop index, compare outputs
  integer k; // Loop index, capture channels

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; access completes in the cycle waitrequest is low
  wire acc = ~waitrequest;
  wire wrStb = write & acc;
  wire hiSel = address[2];
  wire [2:0] ch = address[5:3];
  wire inCm = (address[7:6] == `ADDR_CM_REGION);
  wire inCap = (address[7:6] == `ADDR_CAP_REGION) && (ch < NCAP);
  wire [7:0] wb = writedata[7:0];
  wire ctOvf = ctRun_r & (ctCount_r == `TIMER_MAX);

  // Edge direction per capture channel
  assign riseSel = {t2Control_r[`EDGE_SEL_FOUR_BIT], 3'b111,
                    t2Control_r[`EDGE_SEL_ZERO_BIT]}; // [R10] [R11]

  capture_edge_detect #(
    .WIDTH(NCAP)
  ) edgeDet (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pinIn(captureIn),
    .riseSel(riseSel),
    .edgeHit_r(edgeHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon handshake and read data
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else if (!waitrequest)
      waitrequest <= 1'b1;
    else if (read | write)
    begin
      waitrequest <= 1'b0;
      readdata <= 32'h00000000;
      if (read)
      begin
        if (inCm)
          readdata <= getByte(cmReg[ch], hiSel);
        else if (inCap)
          readdata <= getByte(capReg[ch], hiSel);
        else
          case (address)
            `ADDR_TIME_BASE_SEL: readdata <= {24'h000000, timeBaseSel_r};
            `ADDR_CH_ENABLE: readdata <= {24'h000000, chEnable_r};
            `ADDR_RELOAD_LO: readdata <= getByte(reload_r, 1'b0);
            `ADDR_RELOAD_HI: readdata <= getByte(reload_r, 1'b1);
            `ADDR_CAP_MODE: readdata <= {27'h0000000, capMode_r};
            `ADDR_T2_CONTROL: readdata <= {30'h00000000, t2Control_r};
            `ADDR_EXT_FLAGS: readdata <= {27'h0000000, extRequestFlag};
            `ADDR_CT_STATUS: readdata <= {30'h00000000, ctOvfFlag_r, ctRun_r};
            default: readdata <= 32'h00000000;
          endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timeBaseSel_r <= `RST_TIME_BASE_SEL; // [R2]
      chEnable_r <= `RST_CH_ENABLE;
      capMode_r <= `RST_CAP_MODE;
      t2Control_r <= `RST_T2_CONTROL;
    end
    else if (wrStb)
    begin
      case (address)
        `ADDR_TIME_BASE_SEL: timeBaseSel_r <= wb;
        `ADDR_CH_ENABLE: chEnable_r <= wb;
        `ADDR_CAP_MODE: capMode_r <= wb[NCAP-1:0]; // [R18]
        `ADDR_T2_CONTROL: t2Control_r <= wb[1:0];
        default: t2Control_r <= t2Control_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare timer: reload write starts it, overflow reloads
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reload_r <= `RST_WORD16;
      ctCount_r <= `RST_WORD16;
      ctRun_r <= 1'b0;
      ctOvfFlag_r <= 1'b0;
    end
    else
    begin
      if (wrStb && address == `ADDR_RELOAD_HI)
        reload_r <= setByte(reload_r, 1'b1, wb);
      if (wrStb && address == `ADDR_RELOAD_LO)
      begin
        reload_r <= setByte(reload_r, 1'b0, wb);
        ctCount_r <= {reload_r[15:8], wb};
        ctRun_r <= 1'b1; // [R5]
      end
      else if (ctOvf)
        ctCount_r <= reload_r;
      else if (ctRun_r)
        ctCount_r <= ctCount_r + 16'h0001;
      // Sticky overflow flag, write one to clear; a new overflow wins
      if (ctOvf)
        ctOvfFlag_r <= 1'b1;
      else if (wrStb && address == `ADDR_CT_STATUS && wb[`CT_OVF_BIT])
        ctOvfFlag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare register and compare latch per channel
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmLowWr_r <= {NCM{1'b0}};
      for (i = 0; i < NCM; i = i + 1)
      begin
        cmReg[i] <= `RST_WORD16;
        cmLatch[i] <= `RST_WORD16;
      end
    end
    else
    begin
      for (i = 0; i < NCM; i = i + 1)
      begin
        if (wrStb && inCm && ch == i)
          cmReg[i] <= setByte(cmReg[i], hiSel, wb);
        if (timeBaseSel_r[i])
        begin
          // Buffered mode 0 on the compare timer
          if (ctOvf && cmLowWr_r[i])
            cmLatch[i] <= cmReg[i]; // [R3] [R19]
          if (wrStb && inCm && ch == i && !hiSel)
            cmLowWr_r[i] <= 1'b1; // [R19]
          else if (ctOvf)
            cmLowWr_r[i] <= 1'b0; // [R19]
        end
        else
        begin
          // Mode 1 on timer 2: full word moves on low-byte write only
          cmLowWr_r[i] <= 1'b0;
          if (wrStb && inCm && ch == i && !hiSel)
            cmLatch[i] <= {cmReg[i][15:8], wb}; // [R1] [R6] [R7]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare outputs, gated by channel enable
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      compareOut <= {NCM{1'b0}};
    else
      for (j = 0; j < NCM; j = j + 1)
        compareOut[j] <= chEnable_r[j] &
          ((timeBaseSel_r[j] ? ctCount_r : timerTwoCount) >= cmLatch[j]); // [R20] [R6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture registers and external request flags
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      swCap_r <= {NCAP{1'b0}};
      extRequestFlag <= {NCAP{1'b0}};
      for (k = 0; k < NCAP; k = k + 1)
        capReg[k] <= `RST_WORD16;
    end
    else
    begin
      for (k = 0; k < NCAP; k = k + 1)
      begin
        // Software capture armed by low-byte write in mode 1
        swCap_r[k] <= wrStb && inCap && ch == k && !hiSel && capMode_r[k]; // [R16] [R21]
        if ((edgeHit[k] && !capMode_r[k]) || swCap_r[k])
          capReg[k] <= timerTwoCount; // [R9] [R14] [R16]
        else if (wrStb && inCap && ch == k)
          capReg[k] <= setByte(capReg[k], hiSel, wb); // [R21]
        // Request flag: pin edge in mode 0 only; set wins over clear
        if (edgeHit[k] && !capMode_r[k])
          extRequestFlag[k] <= 1'b1; // [R15] [R17]
        else if (wrStb && address == `ADDR_EXT_FLAGS && wb[k])
          extRequestFlag[k] <= 1'b0;
      end
    end
  end

endmodule // compare_latch_and_capture

//--- sim/compare_latch_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the compare and capture block
module compare_latch_asserts #(
  parameter NCM = 8,
  parameter NCAP = 5
) (
  input wire clk_sys, // Clock
  input wire sys_rst, // Reset
  input wire [7:0] address, // Bus address
  input wire read, // Bus read
  input wire write, // Bus write
  input wire [31:0] writedata, // Bus write data
  input wire [31:0] readdata, // Bus read data
  input wire waitrequest, // Bus wait
  input wire [15:0] timerTwoCount, // Time base
  input wire [NCAP-1:0] captureIn, // Capture pins
  input wire [NCM-1:0] compareOut, // Compare outputs
  input wire [NCAP-1:0] extRequestFlag // Request flags
);
  reg [NCM-1:0] enR;
  reg [NCAP-1:0] pinPrev;
  reg [3:0] quietCnt;
  // Shadow of channel enables; cycles since any capture pin moved
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      enR <= {NCM{1'b0}};
      pinPrev <= {NCAP{1'b1}};
      quietCnt <= 4'h0;
    end
    else
    begin
      if (write && !waitrequest && address == 8'h84)
        enR <= writedata[NCM-1:0];
      pinPrev <= captureIn;
      if (captureIn != pinPrev)
        quietCnt <= 4'h0;
      else if (quietCnt != 4'hf)
        quietCnt <= quietCnt + 4'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence accTaken; (read || write) && waitrequest; endsequence
  sequence oneWait; !waitrequest ##1 waitrequest; endsequence
  chk_wait_once:
    assert property (accTaken |=> oneWait) else $error("bus wait not one cycle");
  chk_no_answer:
    assert property (!read && !write && waitrequest |=> waitrequest) else $error("answer unasked");
  chk_upper_zero:
    assert property (!waitrequest |-> readdata[31:8] == 24'h0) else $error("read data high bits");
  chk_rdata_hold:
    assert property (!read && !write |=> $stable(readdata)) else $error("read data moved");
  chk_enable_gate:
    assert property ((compareOut & ~$past(enR)) == {NCM{1'b0}}) else $error("output while disabled");
  chk_flag_cause:
    assert property ((extRequestFlag & ~$past(extRequestFlag)) != 0 |-> quietCnt < 4'h8)
    else $error("flag without pin edge");
  chk_flag_quiet:
    assert property (quietCnt == 4'hf && !(write && address == 8'h98) |=> $stable(extRequestFlag))
    else $error("flag moved without cause");
  chk_reset_clear:
    assert property ($fell(sys_rst) |-> compareOut == 0 && extRequestFlag == 0 && waitrequest)
    else $error("outputs not cleared by reset");
endmodule // compare_latch_asserts

//--- sim/capture_source.sv
`timescale 1ns/1ps
// Capture signal sources; each level is held four cycles so the sampler sees it
module capture_source (
  input wire clk_sys, // Clock
  input wire [4:0] pinLevel, // Level asked by the bench
  output reg [4:0] captureIn = 5'h1f // Pin levels, idle high
);
  reg [1:0] holdCnt = 2'h3;
  // Follow the asked level only after the old one has stood long enough
  always @(posedge clk_sys)
  begin
    if (pinLevel != captureIn && holdCnt == 2'h3)
    begin
      captureIn <= pinLevel;
      holdCnt <= 2'h0;
    end
    else if (holdCnt != 2'h3)
      holdCnt <= holdCnt + 2'h1;
  end
endmodule // capture_source

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] address = 8'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [15:0] timerTwoCount = 16'h0;
  reg [4:0] pinLevel = 5'h1f;
  reg [31:0] lfsr = 32'h6488f2b8;
  reg [15:0] cap = 16'h0;
  reg [31:0] expQ[$];
  wire [31:0] readdata;
  wire waitrequest;
  wire [4:0] captureIn;
  wire [7:0] compareOut;
  wire [4:0] extRequestFlag;
  integer error_cnt = 0;
  integer checks = 0;
  integer i;
  integer n;
  always #10 clk_sys = ~clk_sys;
  compare_latch_and_capture i_compare_latch_and_capture (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .timerTwoCount(timerTwoCount), .captureIn(captureIn),
    .compareOut(compareOut), .extRequestFlag(extRequestFlag));
  capture_source i_capture_source (.clk_sys(clk_sys), .pinLevel(pinLevel), .captureIn(captureIn));
  ////////////////////////////////////////////////////////////////////////////////
  function [31:0] nextRand(input [31:0] s);
    nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // Bus master: hold the request until wait is seen low
  task busAcc(input [7:0] a, input [7:0] d, input wr);
  begin
    @(posedge clk_sys);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    @(posedge clk_sys);
    while (waitrequest) @(posedge clk_sys);
    write <= 1'b0;
    read <= 1'b0;
  end
  endtask
  task busWr(input [7:0] a, input [7:0] d);
    busAcc(a, d, 1'b1);
  endtask
  task busRd(input [7:0] a, input [31:0] e);
  begin
    expQ.push_back(e);
    busAcc(a, 8'h00, 1'b0);
  end
  endtask
  task newCount;
  begin
    @(posedge clk_sys);
    lfsr = nextRand(lfsr);
    cap = lfsr[15:0] & 16'hfffe;
    timerTwoCount <= cap;
  end
  endtask
  task settle;
    repeat (2) @(posedge clk_sys);
  endtask
  task countHigh;
  begin
    n = 0;
    repeat (256) @(posedge clk_sys) n = n + compareOut[1];
  end
  endtask
  // Read monitor: oldest expectation against the answered data
  always @(posedge clk_sys)
    if (read && !waitrequest)
      check(readdata, expQ.pop_front());
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
      busRd(8'h80 + i[7:0] * 8'h04, 32'h0);
    busWr(8'he8, 8'h55);
    busRd(8'he8, 32'h0);
    // Timer 2 channel: only the low byte write moves the whole value
    newCount;
    busWr(8'h84, 8'h01);
    busWr(8'h04, 8'hff);
    busWr(8'h00, 8'hff);
    settle;
    check(compareOut[0], 1'b0);
    busWr(8'h04, 8'h00);
    settle;
    check(compareOut[0], 1'b0);
    busWr(8'h00, 8'h00);
    settle;
    check(compareOut[0], 1'b1);
    busWr(8'h84, 8'h00);
    settle;
    check(compareOut[0], 1'b0);
    // Preload: first period value direct in mode 1, second one buffered in mode 0
    busWr(8'h0c, 8'hff);
    busWr(8'h08, 8'hf8);
    busWr(8'h80, 8'h02);
    busWr(8'h0c, 8'hff);
    busWr(8'h08, 8'hf0);
    busWr(8'h84, 8'h02);
    busRd(8'h9c, 32'h0);
    busWr(8'h8c, 8'hff);
    busWr(8'h88, 8'h00);
    busRd(8'h9c, 32'h1);
    // First period runs on the preloaded value, 8 counts from 0xfff8 up
    countHigh;
    check(n, 8);
    repeat (300) @(posedge clk_sys);
    countHigh;
    check(n, 16);
    busWr(8'h0c, 8'h00);
    repeat (300) @(posedge clk_sys);
    countHigh;
    check(n, 16);
    check(compareOut[7:2], 6'h00);
    // Pin captures: falling on outer channels, then rising on all
    newCount;
    pinLevel <= 5'h00;
    repeat (12) @(posedge clk_sys);
    check(extRequestFlag, 5'h11);
    busRd(8'h98, 32'h11);
    busRd(8'hc0, cap[7:0]);
    busRd(8'he4, cap[15:8]);
    busWr(8'h98, 8'h1f);
    busWr(8'h94, 8'h03);
    newCount;
    pinLevel <= 5'h1f;
    repeat (12) @(posedge clk_sys);
    check(extRequestFlag, 5'h1f);
    busRd(8'h98, 32'h1f);
    for (i = 0; i < 5; i = i + 1)
    begin
      busRd(8'hc0 + i[7:0] * 8'h08, cap[7:0]);
      busRd(8'hc4 + i[7:0] * 8'h08, cap[15:8]);
    end
    // Software capture on channel one, pins still live on channel two
    busWr(8'h98, 8'h1f);
    busWr(8'h90, 8'h02);
    newCount;
    busWr(8'hcc, 8'h5a);
    busRd(8'hcc, 32'h5a);
    busWr(8'hc8, 8'h00);
    busRd(8'hc8, cap[7:0]);
    busRd(8'hcc, cap[15:8]);
    pinLevel <= 5'h19;
    repeat (12) @(posedge clk_sys);
    pinLevel <= 5'h1f;
    repeat (12) @(posedge clk_sys);
    busRd(8'h98, 32'h04);
    check(extRequestFlag, 5'h04);
    print_verdict;
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    error_cnt = error_cnt + 1;
    print_verdict;
  end
endmodule // testbench
bind compare_latch_and_capture compare_latch_asserts #(.NCM(NCM), .NCAP(NCAP))
  i_compare_latch_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .timerTwoCount(timerTwoCount), .captureIn(captureIn), .compareOut(compareOut),
  .extRequestFlag(extRequestFlag));
